// *** hdl/charger_emulation_pkg.sv ***
// Constants and types shared by the charger emulation sequencer
package charger_emulation_pkg;

  // Profile indices: legacy zero through six, then custom at seven
  localparam int          PROFILE_COUNT   = 8;
  localparam int          PROFILE_IDX_W   = 3;
  localparam logic [2:0]  PROFILE_FIRST   = 3'h0;
  localparam logic [2:0]  PROFILE_LAST    = 3'h7;
  localparam logic [2:0]  PROFILE_CUSTOM  = 3'h7;
  localparam logic [2:0]  PROFILE_DCP     = 3'h2;

  // Reset values of configuration
  localparam logic [7:0]  PROFILE_EN_RST  = 8'h7f;

  // Timing, figures in microseconds and the cycle rate of the clock
  localparam int          CLK_MHZ               = 100;
  localparam int          EMULATION_RESET_US    = 1000;
  localparam int          PROFILE_TIMEOUT_US    = 1000;
  localparam int          DISCHARGE_US          = 200;
  localparam int          CNT_W                 = 24;
  localparam int          EMULATION_RESET_CYC   = EMULATION_RESET_US * CLK_MHZ;
  localparam int          PROFILE_TIMEOUT_CYC   = PROFILE_TIMEOUT_US * CLK_MHZ;
  localparam int          DISCHARGE_CYC         = DISCHARGE_US * CLK_MHZ;

  // Active mode decode
  typedef enum logic [1:0] {
    MODE_OTHER,
    MODE_DCP,
    MODE_CYCLE
  } active_mode_e;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EMU_RESET,
    ST_APPLY,
    ST_ACCEPTED,
    ST_DCP_HOLD,
    ST_NO_HANDSHAKE
  } seq_state_e;

  // Current limit encodings
  localparam logic CLIM_TRIP = 1'b0;
  localparam logic CLIM_CC   = 1'b1;

endpackage : charger_emulation_pkg

// *** hdl/charger_emulation_sequencer.sv ***
// Charger emulation sequencer: DCP mode and dedicated charger emulation cycle
`timescale 1ns/10ps

module charger_emulation_sequencer
  import charger_emulation_pkg::*;
#(
  parameter logic [CNT_W-1:0] EMULATION_RESET_CNT = CNT_W'(EMULATION_RESET_CYC),
  parameter logic [CNT_W-1:0] DISCHARGE_CNT       = CNT_W'(DISCHARGE_CYC),
  parameter logic [CNT_W-1:0] PROFILE_TIMEOUT_CNT = CNT_W'(PROFILE_TIMEOUT_CYC)
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     attach_detect_enable_i,
  input  wire logic                     emulation_enable_i,
  input  wire logic                     mode_select_a_i,
  input  wire logic                     mode_select_b_i,
  input  wire logic                     port_power_enable_i,
  input  wire logic                     custom_profile_first_i,
  input  wire logic                     emulation_retry_enable_i,
  input  wire logic                     timeout_enable_i,
  input  wire logic [PROFILE_COUNT-1:0] profile_enable_i,
  input  wire logic [CNT_W-1:0]         profile_timeout_cnt_i [PROFILE_COUNT],
  input  wire logic                     device_attached_i,
  input  wire logic                     bus_above_charge_threshold_i,
  output logic                          port_power_switch_o,
  output logic                          bus_discharge_o,
  output logic                          data_pulldown_o,
  output logic                          data_short_resistor_o,
  output logic                          data_pin_current_limit_o,
  output logic                          high_speed_switch_o,
  output logic                          current_limit_cc_o,
  output logic                          profile_active_o,
  output logic [PROFILE_IDX_W-1:0]      profile_index_o,
  output logic                          profile_accepted_o,
  output logic                          attach_detect_active_o,
  output logic                          no_handshake_flag_o
);

  // Mode decode from the three controls
  function automatic active_mode_e decode_mode(input logic a, input logic b, input logic en);
    if (!en) begin
      decode_mode = MODE_OTHER;
    end else if (!b) begin
      decode_mode = MODE_CYCLE;
    end else if (!a) begin
      decode_mode = MODE_DCP;
    end else begin
      decode_mode = MODE_OTHER;
    end
  endfunction : decode_mode

  seq_state_e                 state_r;
  seq_state_e                 state_nxt;
  active_mode_e               mode_r;
  logic [CNT_W-1:0]           cnt_r;
  logic [CNT_W-1:0]           cnt_nxt;
  logic [PROFILE_IDX_W-1:0]   idx_r;
  logic [PROFILE_IDX_W-1:0]   idx_nxt;
  logic                       custom_done_r; // Custom already tried at head of pass
  logic                       custom_done_nxt;
  logic                       nohs_r;
  logic                       nohs_nxt;
  logic                       accepted_r;
  logic                       accepted_nxt;

  wire active_mode_e mode_now = decode_mode(mode_select_a_i, mode_select_b_i,
                                            emulation_enable_i);
  wire logic mode_change = (mode_now != mode_r);
  wire logic dcp_mode    = (mode_now == MODE_DCP);

  // Effective enables: custom profile only if enabled, legacy as given
  wire logic [PROFILE_COUNT-1:0] en_mask = profile_enable_i;

  // Search for the next enabled profile, custom included unless masked, at or after a start index
  function automatic logic [PROFILE_IDX_W:0] find_next(input logic [PROFILE_COUNT-1:0] en,
                                                       input logic [PROFILE_IDX_W-1:0] from);
    logic [PROFILE_IDX_W:0] res;
    res = {1'b1, PROFILE_FIRST};
    for (int i = PROFILE_COUNT - 1; i >= 0; i--) begin
      if (en[i] && (PROFILE_IDX_W'(i) >= from)) begin
        res = {1'b0, PROFILE_IDX_W'(i)};
      end
    end
    find_next = res;
  endfunction : find_next

  // First profile of a sequence: custom first if so configured
  wire logic                     custom_lead = custom_profile_first_i
                                               && en_mask[PROFILE_CUSTOM];
  wire logic [PROFILE_IDX_W:0]   first_srch  = find_next(en_mask & ~(PROFILE_COUNT'(custom_lead)
                                                         << PROFILE_CUSTOM), PROFILE_FIRST);
  wire logic [PROFILE_IDX_W:0]   next_srch   = find_next(en_mask & ~(PROFILE_COUNT'(custom_done_r)
                                                         << PROFILE_CUSTOM),
                                                         idx_r + PROFILE_IDX_W'(1));
  wire logic                     at_last     = (idx_r == PROFILE_LAST) && !custom_done_r;
  wire logic                     none_left   = next_srch[PROFILE_IDX_W] || at_last;

  // Per-profile terminal counts; a zero entry falls back to the default
  logic [CNT_W-1:0] tmo_eff [PROFILE_COUNT];
  for (genvar g = 0; g < PROFILE_COUNT; g++) begin : g_tmo
    assign tmo_eff[g] = (profile_timeout_cnt_i[g] == '0) ? PROFILE_TIMEOUT_CNT
                        : profile_timeout_cnt_i[g];
  end

  // Timeout for the profile under test; a disabled timeout never expires
  wire logic [CNT_W-1:0] tmo_cnt = tmo_eff[idx_r];
  wire logic             tmo_hit = timeout_enable_i && (cnt_r >= tmo_cnt - CNT_W'(1));
  wire logic             rst_hit = (cnt_r >= EMULATION_RESET_CNT - CNT_W'(1));

  // Next-state logic of the sequencer
  always_comb begin
    state_nxt       = state_r;
    cnt_nxt         = cnt_r + CNT_W'(1);
    idx_nxt         = idx_r;
    custom_done_nxt = custom_done_r;
    nohs_nxt        = nohs_r;
    accepted_nxt    = accepted_r;
    if (mode_change || !port_power_enable_i) begin
      state_nxt    = ST_IDLE;
      cnt_nxt      = '0;
      accepted_nxt = 1'b0;
      nohs_nxt     = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_nxt = '0;
          if (mode_now != MODE_OTHER) begin
            state_nxt       = ST_EMU_RESET;
            custom_done_nxt = custom_lead;
            idx_nxt         = custom_lead ? PROFILE_CUSTOM
                              : first_srch[PROFILE_IDX_W-1:0];
            if (dcp_mode) begin
              idx_nxt = PROFILE_DCP;
            end
          end
        end
        ST_EMU_RESET: begin
          if (rst_hit) begin
            state_nxt = dcp_mode ? ST_DCP_HOLD : ST_APPLY;
            cnt_nxt   = '0;
            if (!dcp_mode && first_srch[PROFILE_IDX_W] && !custom_lead) begin
              state_nxt = ST_NO_HANDSHAKE;
              nohs_nxt  = 1'b1;
            end
          end
        end
        ST_APPLY: begin
          if (tmo_hit) begin
            cnt_nxt = '0;
            if (bus_above_charge_threshold_i) begin
              state_nxt    = ST_ACCEPTED;
              accepted_nxt = 1'b1;
            end else if (!none_left) begin
              state_nxt       = ST_EMU_RESET;
              idx_nxt         = next_srch[PROFILE_IDX_W-1:0];
            end else if (emulation_retry_enable_i) begin
              state_nxt       = ST_EMU_RESET;
              custom_done_nxt = custom_lead;
              idx_nxt         = custom_lead ? PROFILE_CUSTOM
                                : first_srch[PROFILE_IDX_W-1:0];
            end else begin
              state_nxt = ST_NO_HANDSHAKE;
              nohs_nxt  = 1'b1;
            end
          end
        end
        ST_ACCEPTED: begin
          cnt_nxt = '0;
        end
        ST_DCP_HOLD: begin
          cnt_nxt = '0;
        end
        ST_NO_HANDSHAKE: begin
          cnt_nxt  = '0;
          nohs_nxt = 1'b1;
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer state and dwell counter
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Mode last seen, for change detection
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_r <= MODE_OTHER;
    end else begin
      mode_r <= mode_now;
    end
  end

  // Profile pointer and custom-first bookkeeping
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      idx_r         <= PROFILE_FIRST;
      custom_done_r <= 1'b0;
    end else begin
      idx_r         <= idx_nxt;
      custom_done_r <= custom_done_nxt;
    end
  end

  // Status flags
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      nohs_r     <= 1'b0;
      accepted_r <= 1'b0;
    end else begin
      nohs_r     <= nohs_nxt;
      accepted_r <= accepted_nxt;
    end
  end

  // Output decode from next state
  wire logic in_reset_n  = (state_nxt == ST_EMU_RESET);
  wire logic applying_n  = (state_nxt == ST_APPLY) || (state_nxt == ST_DCP_HOLD)
                           || (state_nxt == ST_ACCEPTED);
  wire logic dcp_prof_n  = (state_nxt == ST_DCP_HOLD)
                           || (applying_n && (idx_nxt == PROFILE_DCP));
  wire logic discharge_n = in_reset_n && (cnt_nxt < DISCHARGE_CNT);
  wire logic cc_n        = (state_nxt == ST_DCP_HOLD) || (state_nxt == ST_APPLY)
                           || ((state_nxt == ST_ACCEPTED) && (idx_nxt == PROFILE_DCP));

  // Supply and pin drive decode
  wire logic power_n     = applying_n || (state_nxt == ST_NO_HANDSHAKE);
  wire logic pin_limit_n = applying_n && (state_nxt != ST_NO_HANDSHAKE);

  // Port power switch: open during emulation reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      port_power_switch_o <= 1'b0;
    end else begin
      port_power_switch_o <= power_n;
    end
  end

  // Bus discharge over the first part of the reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      bus_discharge_o <= 1'b0;
    end else begin
      bus_discharge_o <= discharge_n;
    end
  end

  // Data pin pull-downs for the whole reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      data_pulldown_o <= 1'b0;
    end else begin
      data_pulldown_o <= in_reset_n;
    end
  end

  // Data short resistor and pin current limit
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      data_short_resistor_o    <= 1'b0;
      data_pin_current_limit_o <= 1'b0;
    end else begin
      data_short_resistor_o    <= dcp_prof_n;
      data_pin_current_limit_o <= pin_limit_n;
    end
  end

  // High-speed switch kept open; current limit mode
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      high_speed_switch_o <= 1'b0;
      current_limit_cc_o  <= CLIM_TRIP;
    end else begin
      high_speed_switch_o <= 1'b0;
      current_limit_cc_o  <= cc_n ? CLIM_CC : CLIM_TRIP;
    end
  end

  // Profile under test
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      profile_active_o <= 1'b0;
      profile_index_o  <= PROFILE_FIRST;
    end else begin
      profile_active_o <= applying_n;
      profile_index_o  <= idx_nxt;
    end
  end

  // Acceptance report
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      profile_accepted_o <= 1'b0;
    end else begin
      profile_accepted_o <= accepted_nxt;
    end
  end

  // Attach and removal detection follows its enable
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      attach_detect_active_o <= 1'b0;
    end else begin
      attach_detect_active_o <= attach_detect_enable_i;
    end
  end

  // No-handshake flag, held until power drops or the mode changes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      no_handshake_flag_o <= 1'b0;
    end else begin
      no_handshake_flag_o <= nohs_nxt;
    end
  end

  // Attach state is only a hint; cycling continues regardless
  wire logic unused_attach = device_attached_i;

endmodule : charger_emulation_sequencer

// *** tb/charger_emulation_props.sv ***
// Concurrent checks on the charger emulation sequencer ports
`timescale 1ns/10ps
module charger_emulation_props
  import charger_emulation_pkg::*;
#(
  parameter logic [CNT_W-1:0] EMULATION_RESET_CNT = CNT_W'(20),
  parameter logic [CNT_W-1:0] DISCHARGE_CNT       = CNT_W'(5),
  parameter logic [CNT_W-1:0] PROFILE_TIMEOUT_CNT = CNT_W'(30)
) (
  input wire logic                     sys_clk_i,
  input wire logic                     rst_i,
  input wire logic                     emulation_enable_i,
  input wire logic                     mode_select_a_i,
  input wire logic                     mode_select_b_i,
  input wire logic                     port_power_enable_i,
  input wire logic [CNT_W-1:0]         profile_timeout_cnt_i [PROFILE_COUNT],
  input wire logic                     bus_above_charge_threshold_i,
  input wire logic                     port_power_switch_o,
  input wire logic                     bus_discharge_o,
  input wire logic                     data_pulldown_o,
  input wire logic                     data_pin_current_limit_o,
  input wire logic                     high_speed_switch_o,
  input wire logic                     current_limit_cc_o,
  input wire logic                     profile_active_o,
  input wire logic [PROFILE_IDX_W-1:0] profile_index_o,
  input wire logic                     profile_accepted_o,
  input wire logic                     no_handshake_flag_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [CNT_W-1:0] pd_cnt_r, dc_cnt_r, ap_cnt_r;
  logic [2:0]       idx_r, md1_r, md2_r;
  logic             pwr_r;
  wire  [2:0]       mode_w = {emulation_enable_i, mode_select_a_i, mode_select_b_i};
  wire              calm_w = port_power_enable_i && pwr_r && mode_w == md1_r && md1_r == md2_r;
  wire  [CNT_W-1:0] lim_w = (profile_timeout_cnt_i[idx_r] == '0) ? PROFILE_TIMEOUT_CNT
                                                                 : profile_timeout_cnt_i[idx_r];
  // Run lengths of reset, discharge and applied profile
  always_ff @(posedge sys_clk_i) begin
    pd_cnt_r <= data_pulldown_o ? pd_cnt_r + 1'b1 : '0;
    dc_cnt_r <= bus_discharge_o ? dc_cnt_r + 1'b1 : '0;
    ap_cnt_r <= profile_active_o ? ap_cnt_r + 1'b1 : '0;
    idx_r <= profile_active_o ? profile_index_o : idx_r;
    md1_r <= mode_w;
    md2_r <= md1_r;
    pwr_r <= port_power_enable_i;
  end
  a_hs_open: assert property (!high_speed_switch_o)
    else $error("high-speed switch closed");
  a_reset_pins: assert property (
    data_pulldown_o |-> !port_power_switch_o && !profile_active_o)
    else $error("power or profile during reset");
  a_profile_live: assert property (
    profile_active_o |-> port_power_switch_o && data_pin_current_limit_o)
    else $error("profile without power or pin limit");
  a_reset_len: assert property (
    $fell(data_pulldown_o) && profile_active_o |-> pd_cnt_r == EMULATION_RESET_CNT)
    else $error("reset length wrong");
  a_discharge_len: assert property (
    $fell(bus_discharge_o) && data_pulldown_o |-> dc_cnt_r == DISCHARGE_CNT)
    else $error("discharge length wrong");
  a_accept_cause: assert property (
    $rose(profile_accepted_o) |-> $past(bus_above_charge_threshold_i))
    else $error("accepted without current");
  a_reject_time: assert property (
    $fell(profile_active_o) && data_pulldown_o
    |-> ap_cnt_r == lim_w && !$past(bus_above_charge_threshold_i))
    else $error("reject timing wrong");
  a_nohs_trip: assert property (
    no_handshake_flag_o |-> !current_limit_cc_o && !profile_active_o)
    else $error("no handshake not trip");
  a_flag_sticky: assert property (no_handshake_flag_o && calm_w |=> no_handshake_flag_o)
    else $error("flag dropped");
  a_accept_limit: assert property (
    profile_accepted_o |-> current_limit_cc_o == (profile_index_o == PROFILE_DCP))
    else $error("accepted limit mode wrong");
endmodule : charger_emulation_props
bind charger_emulation_sequencer charger_emulation_props #(
  .EMULATION_RESET_CNT(EMULATION_RESET_CNT), .DISCHARGE_CNT(DISCHARGE_CNT),
  .PROFILE_TIMEOUT_CNT(PROFILE_TIMEOUT_CNT)) props_i (.*);

// *** tb/portable_device_model.sv ***
// Attached portable device that draws charge current for one profile
`timescale 1ns/10ps
module portable_device_model (
  input  wire logic       power_i,
  input  wire logic       active_i,
  input  wire logic [2:0] index_i,
  input  wire logic [3:0] want_i,
  output logic            draw_o
);
  // Draws only with bus power on and its own profile applied; 8 means never
  assign draw_o = power_i && active_i && !want_i[3] && index_i == want_i[2:0];
endmodule : portable_device_model

// *** tb/charger_emulation_sequencer_tb_top.sv ***
// Self-checking bench of the charger emulation sequencer
`timescale 1ns/10ps
module charger_emulation_sequencer_tb_top;
  import charger_emulation_pkg::*;
  logic sys_clk_i, rst_i, attach_detect_enable_i, emulation_enable_i, mode_select_a_i;
  logic mode_select_b_i, port_power_enable_i, custom_profile_first_i, emulation_retry_enable_i;
  logic timeout_enable_i, device_attached_i, bus_above_charge_threshold_i;
  logic [7:0] profile_enable_i;
  logic [CNT_W-1:0] profile_timeout_cnt_i [PROFILE_COUNT];
  logic port_power_switch_o, bus_discharge_o, data_pulldown_o, data_short_resistor_o;
  logic data_pin_current_limit_o, high_speed_switch_o, current_limit_cc_o, profile_active_o;
  logic profile_accepted_o, attach_detect_active_o, no_handshake_flag_o, act_d;
  logic [2:0] profile_index_o;
  logic [3:0] want;
  logic [31:0] seed;
  int err_count, cmp_count, kind;
  logic [2:0] got[$], exp_q[$];
  charger_emulation_sequencer #(.EMULATION_RESET_CNT(24'h14), .DISCHARGE_CNT(24'h5),
    .PROFILE_TIMEOUT_CNT(24'h1e)) uut (.*);
  portable_device_model dev (.power_i(port_power_switch_o), .active_i(profile_active_o),
    .index_i(profile_index_o), .want_i(want), .draw_o(bus_above_charge_threshold_i));
  initial begin
    sys_clk_i = 0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // Records each newly applied profile
  always @(posedge sys_clk_i) begin
    if (!rst_i && profile_active_o === 1'b1 && act_d !== 1'b1) got.push_back(profile_index_o);
    act_d = profile_active_o;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // Expected profile order: custom first or last, stop at the accepted one
  task automatic plan(input logic [7:0] en, input bit cf, input int acc, input int passes);
    int i;
    exp_q.delete();
    for (int p = 0; p < passes; p++) begin
      for (int k = 0; k < 8; k++) begin
        i = cf ? (k + 7) % 8 : k;
        if (en[i]) exp_q.push_back(3'(i));
        if (en[i] && i == acc) return;
      end
    end
  endtask : plan
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  function automatic bit done();
    return kind == 0 ? profile_accepted_o === 1'b1 : kind == 1 ? no_handshake_flag_o === 1'b1
                     : got.size() >= exp_q.size();
  endfunction : done
  // Runs one emulation cycle and checks the order of applied profiles
  task automatic go(input logic [7:0] en, input bit cf, input bit rt, input int acc, input int ps);
    @(posedge sys_clk_i) #1;
    plan(en, cf, acc, ps);
    got.delete();
    profile_enable_i = en;
    custom_profile_first_i = cf;
    emulation_retry_enable_i = rt;
    want = 4'(acc);
    kind = acc < 8 ? 0 : rt ? 2 : 1;
    {emulation_enable_i, mode_select_a_i, mode_select_b_i, port_power_enable_i} =
      {1'b1, cf, 1'b0, 1'b1};
    for (int t = 0; t < 4000 && !done(); t++) @(posedge sys_clk_i) #1;
    cmp(8'(got.size() >= exp_q.size()), 8'h1);
    foreach (exp_q[j]) cmp(8'(got[j]), 8'(exp_q[j]));
  endtask : go
  task automatic pwr_off();
    @(posedge sys_clk_i) #1;
    port_power_enable_i = 0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    cmp({profile_active_o, no_handshake_flag_o, profile_accepted_o}, 8'h0);
  endtask : pwr_off
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    wrap_up();
  end
  initial begin
    {attach_detect_enable_i, emulation_enable_i, mode_select_a_i, mode_select_b_i} = 4'h8;
    {port_power_enable_i, custom_profile_first_i, emulation_retry_enable_i} = 3'h0;
    {timeout_enable_i, device_attached_i, rst_i, act_d} = 4'he;
    profile_enable_i = 8'h7f;
    want = 4'h8;
    seed = 32'hacb5;
    for (int i = 0; i < 8; i++) begin
      seed = nx(seed);
      profile_timeout_cnt_i[i] = 24'(8 + seed[3:0]);
    end
    repeat (16) @(posedge sys_clk_i);
    #1 rst_i = 0;
    go(8'h7f, 0, 0, 4, 1);
    cmp({profile_accepted_o, current_limit_cc_o, high_speed_switch_o}, 8'h4);
    cmp(8'(attach_detect_active_o), 8'h1);
    pwr_off();
    go(8'hff, 1, 0, 8, 1);
    repeat (50) @(posedge sys_clk_i);
    #1 cmp({no_handshake_flag_o, current_limit_cc_o}, 8'h2);
    pwr_off();
    seed = nx(seed);
    go(seed[7:0] | 8'h01, 0, 1, 8, 2);
    pwr_off();
    go(8'h7f, 0, 0, 2, 1);
    cmp({current_limit_cc_o, data_short_resistor_o, high_speed_switch_o}, 8'h6);
    pwr_off();
    // Dedicated charging port mode holds its profile with no timeout
    {emulation_enable_i, mode_select_a_i, mode_select_b_i, port_power_enable_i} = 4'hb;
    attach_detect_enable_i = 0;
    repeat (300) @(posedge sys_clk_i);
    #1 cmp({profile_active_o, data_short_resistor_o, profile_accepted_o}, 8'h6);
    cmp(8'(attach_detect_active_o), 8'h0);
    wrap_up();
  end
endmodule : charger_emulation_sequencer_tb_top
